// ---- learn_key_pkg.sv ----
package learn_key_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int WORD_W = 69;
   localparam int LEN_W = 7;
   localparam int SEED_W = 64;

   localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MFR_LO = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MFR_HI = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_KEY_LO = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_KEY_HI = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_SERIAL = 8'h1C;

   localparam int CFG_METHOD_BIT = 0;
   localparam int CFG_SEED_BIT = 2;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [63:0] MFR_RESET = 64'h0;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;

   localparam int ST_IND_BIT = 0;
   localparam int ST_OK_BIT = 1;
   localparam int ST_FAIL_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   localparam int ST_SER28_BIT = 4;

   localparam logic [3:0] NORMAL_HI_NIBBLE = 4'h6;
   localparam logic [3:0] NORMAL_LO_NIBBLE = 4'h2;
   localparam logic [LEN_W-1:0] LEN_SHORT_A = 7'h42;
   localparam logic [LEN_W-1:0] LEN_SHORT_B = 7'h43;

   localparam int F_SYNC_LSB = 0;
   localparam int F_DISC_LSB = 16;
   localparam int F_OVF_LSB = 26;
   localparam int F_BTN_LSB = 28;
   localparam int F_SER_LSB = 32;
   localparam int F_FUNC28_LSB = 60;
   localparam int F_STAT28_LSB = 64;
   localparam int F_FUNC32_LSB = 64;
   localparam int F_STAT32_LSB = 68;

   localparam logic [1:0] SEED_KIND_32 = 2'h0;
   localparam logic [1:0] SEED_KIND_48 = 2'h1;
   localparam logic [1:0] SEED_KIND_60 = 2'h2;

   localparam logic [9:0] CIPHER_ROUNDS = 10'h210;
   localparam logic [31:0] NLF_TABLE = 32'h3A5C742E;
   localparam int KEY_TAP = 15;
endpackage

// ---- seed_decrypt.sv ----
`timescale 1ns/1ps
`default_nettype none
module seed_decrypt
   import learn_key_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [31:0] data_in,
   input wire logic [63:0] cipher_key,
   output logic [31:0] data_out,
   output logic done
);
   typedef struct packed {
      logic busy;
      logic [9:0] cnt;
      logic [31:0] y;
      logic [63:0] k;
      logic done;
   } dec_t;

   dec_t s_r, s_nxt;

   function automatic logic nlf(input logic [31:0] y);
      nlf = NLF_TABLE[{y[30], y[25], y[19], y[8], y[0]}];
   endfunction

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (start && !s_r.busy) begin
         s_nxt.busy = 1'b1;
         s_nxt.cnt = 10'h0;
         s_nxt.y = data_in;
         s_nxt.k = cipher_key;
      end else if (s_r.busy) begin
         // one round per clock keeps the area to a single nonlinear stage
         s_nxt.y = {s_r.y[30:0], s_r.y[31] ^ s_r.y[15] ^ s_r.k[KEY_TAP] ^ nlf(s_r.y)};
         s_nxt.k = {s_r.k[62:0], s_r.k[63]};
         s_nxt.cnt = s_r.cnt + 10'h1;
         if (s_r.cnt == CIPHER_ROUNDS - 10'h1) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign data_out = s_r.y;
   assign done = s_r.done;
endmodule
`default_nettype wire

// ---- code_word_parser.sv ----
`timescale 1ns/1ps
`default_nettype none
module code_word_parser
   import learn_key_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [WORD_W-1:0] rx_word,
   input wire logic [LEN_W-1:0] rx_len,
   input wire logic rx_valid,
   output logic [3:0] buttons,
   output logic [1:0] ovf_bits,
   output logic [9:0] disc_bits,
   output logic [15:0] sync_value,
   output logic [1:0] status_bits,
   output logic [3:0] func_bits,
   output logic [31:0] serial,
   output logic serial28,
   output logic parsed_valid
);
   typedef struct packed {
      logic [3:0] btn;
      logic [1:0] ovf;
      logic [9:0] disc;
      logic [15:0] sync;
      logic [1:0] stat;
      logic [3:0] func;
      logic [31:0] ser;
      logic s28;
      logic vld;
   } par_t;

   par_t p_r, p_nxt;
   logic short_word;

   assign short_word = (rx_len == LEN_SHORT_A) || (rx_len == LEN_SHORT_B);

   always_comb begin
      p_nxt = p_r;
      p_nxt.vld = rx_valid;
      if (rx_valid) begin
         p_nxt.btn = rx_word[F_BTN_LSB +: 4];
         p_nxt.ovf = rx_word[F_OVF_LSB +: 2];
         p_nxt.disc = rx_word[F_DISC_LSB +: 10];
         p_nxt.sync = rx_word[F_SYNC_LSB +: 16];
         p_nxt.s28 = short_word;
         if (short_word) begin
            p_nxt.ser = {4'h0, rx_word[F_SER_LSB +: 28]};
            p_nxt.func = rx_word[F_FUNC28_LSB +: 4];
            p_nxt.stat = rx_word[F_STAT28_LSB +: 2];
         end else begin
            p_nxt.ser = rx_word[F_SER_LSB +: 32];
            p_nxt.func = rx_word[F_FUNC32_LSB +: 4];
            p_nxt.stat = {1'b0, rx_word[F_STAT32_LSB]};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         p_r <= '0;
      end else begin
         p_r <= p_nxt;
      end
   end

   assign buttons = p_r.btn;
   assign ovf_bits = p_r.ovf;
   assign disc_bits = p_r.disc;
   assign sync_value = p_r.sync;
   assign status_bits = p_r.stat;
   assign func_bits = p_r.func;
   assign serial = p_r.ser;
   assign serial28 = p_r.s28;
   assign parsed_valid = p_r.vld;
endmodule
`default_nettype wire

// ---- learn_key_generator.sv ----
`timescale 1ns/1ps
`default_nettype none
module learn_key_generator
   import learn_key_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [WORD_W-1:0] rx_word,
   input wire logic [LEN_W-1:0] rx_len,
   input wire logic rx_valid,
   input wire logic [SEED_W-1:0] seed_word,
   input wire logic [1:0] seed_kind,
   input wire logic seed_valid,
   input wire logic learn_request_pin_n,
   output logic learn_indication,
   output logic [63:0] crypt_key,
   output logic key_valid,
   output logic erase_all,
   output logic [3:0] buttons,
   output logic [1:0] ovf_bits,
   output logic [9:0] disc_bits,
   output logic [15:0] sync_value,
   output logic [1:0] status_bits,
   output logic [3:0] func_bits,
   output logic [31:0] serial,
   output logic serial28,
   output logic parsed_valid
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_WAIT_SEED = 3'b001,
      S_RUN_HI = 3'b010,
      S_WAIT_HI = 3'b011,
      S_RUN_LO = 3'b100,
      S_WAIT_LO = 3'b101,
      S_DONE = 3'b110
   } state_t;

   typedef struct packed {
      state_t st;
      logic [7:0] cfg;
      logic [63:0] mfr;
      logic [DATA_W-1:0] rdata;
      logic [31:0] seed_hi;
      logic [31:0] seed_lo;
      logic [31:0] ser;
      logic [63:0] key;
      logic key_vld;
      logic erase;
      logic ind;
      logic ok;
      logic fail;
      logic dec_start;
      logic pin_prev;
   } main_t;

   main_t s_r, s_nxt;
   logic [31:0] dec_in;
   logic [31:0] dec_out;
   logic dec_done;
   logic method_xor;
   logic seed_mode;
   logic pin_fall;
   logic start_cmd;
   logic stop_cmd;

   function automatic logic [31:0] xor_half(
      input logic [31:0] seed,
      input logic [31:0] code
   );
      xor_half = seed ^ code;
   endfunction

   function automatic logic [31:0] normal_seed(
      input logic [3:0] nibble,
      input logic [31:0] ser
   );
      normal_seed = {nibble, ser[27:0]};
   endfunction

   function automatic logic ctrl_hit(
      input logic wr,
      input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d,
      input int bit_no
   );
      ctrl_hit = wr && (a == OFS_CTRL) && d[bit_no];
   endfunction

   function automatic logic [31:0] upper_from_seed(
      input logic [SEED_W-1:0] sd,
      input logic [1:0] kind,
      input logic [31:0] ser
   );
      logic [31:0] u;
      u = sd[63:32];
      if (kind == SEED_KIND_32) begin
         u = {4'h0, ser[27:0]};
      end else if (kind == SEED_KIND_48) begin
         u = {ser[31:16], sd[47:32]};
      end else if (kind == SEED_KIND_60) begin
         u = {4'h0, sd[59:32]};
      end
      upper_from_seed = {4'h0, u[27:0]};
   endfunction

   // unmapped offsets and the write-only code registers read as zero
   function automatic logic [DATA_W-1:0] read_word(
      input logic [ADDR_W-1:0] a,
      input main_t s,
      input logic s28
   );
      logic [DATA_W-1:0] w;
      w = '0;
      if (a == OFS_CFG) begin
         w = {24'h0, s.cfg};
      end else if (a == OFS_STATUS) begin
         w[ST_IND_BIT] = s.ind;
         w[ST_OK_BIT] = s.ok;
         w[ST_FAIL_BIT] = s.fail;
         w[ST_BUSY_BIT] = (s.st != S_IDLE);
         w[ST_SER28_BIT] = s28;
      end else if (a == OFS_KEY_LO) begin
         w = s.key[31:0];
      end else if (a == OFS_KEY_HI) begin
         w = s.key[63:32];
      end else if (a == OFS_SERIAL) begin
         w = s.ser;
      end
      read_word = w;
   endfunction

   assign method_xor = s_r.cfg[CFG_METHOD_BIT];
   assign seed_mode = s_r.cfg[CFG_SEED_BIT];
   // pin is already synchronous, so one stage of history is enough for the edge
   assign pin_fall = s_r.pin_prev && !learn_request_pin_n;
   assign start_cmd = ctrl_hit(reg_wr, reg_addr, reg_wdata, CTRL_START_BIT);
   assign stop_cmd = ctrl_hit(reg_wr, reg_addr, reg_wdata, CTRL_STOP_BIT);
   // the core takes its data one cycle after start is raised, in the wait state
   assign dec_in = (s_r.st == S_WAIT_HI) ? s_r.seed_hi : s_r.seed_lo;

   code_word_parser u_parser (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .rx_word(rx_word),
      .rx_len(rx_len),
      .rx_valid(rx_valid),
      .buttons(buttons),
      .ovf_bits(ovf_bits),
      .disc_bits(disc_bits),
      .sync_value(sync_value),
      .status_bits(status_bits),
      .func_bits(func_bits),
      .serial(serial),
      .serial28(serial28),
      .parsed_valid(parsed_valid)
   );

   seed_decrypt u_decrypt (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .start(s_r.dec_start),
      .data_in(dec_in),
      .cipher_key(s_r.mfr),
      .data_out(dec_out),
      .done(dec_done)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.key_vld = 1'b0;
      s_nxt.erase = 1'b0;
      s_nxt.dec_start = 1'b0;
      s_nxt.rdata = '0;
      s_nxt.pin_prev = learn_request_pin_n;

      // register writes
      if (reg_wr) begin
         if (reg_addr == OFS_CFG) begin
            s_nxt.cfg = reg_wdata[7:0];
         end else if (reg_addr == OFS_MFR_LO) begin
            s_nxt.mfr[31:0] = reg_wdata;
         end else if (reg_addr == OFS_MFR_HI) begin
            s_nxt.mfr[63:32] = reg_wdata;
            s_nxt.erase = 1'b1;
         end else if (reg_addr == OFS_CTRL) begin
            if (start_cmd) begin
               s_nxt.ind = 1'b1;
               s_nxt.ok = 1'b0;
               s_nxt.fail = 1'b0;
            end
            if (stop_cmd) begin
               s_nxt.ind = 1'b0;
            end
         end
      end

      // register reads; the manufacturer code is write-only for secrecy
      if (reg_rd) begin
         s_nxt.rdata = read_word(reg_addr, s_r, serial28);
      end

      // learn pin: a low pulse starts learning, or ends it once a key was made
      if (pin_fall) begin
         if (!s_r.ind) begin
            s_nxt.ind = 1'b1;
            s_nxt.ok = 1'b0;
            s_nxt.fail = 1'b0;
         end else if (s_r.ok) begin
            s_nxt.ind = 1'b0;
         end
      end

      case (s_r.st)
         S_IDLE: begin
            if (s_r.ind && !s_r.ok && parsed_valid) begin
               s_nxt.ser = serial;
               if (serial == 32'h0) begin
                  // a zero serial is the test transmitter and is never learned
                  s_nxt.fail = 1'b1;
               end else if (seed_mode) begin
                  s_nxt.st = S_WAIT_SEED;
               end else begin
                  s_nxt.seed_hi = normal_seed(NORMAL_HI_NIBBLE, serial);
                  s_nxt.seed_lo = normal_seed(NORMAL_LO_NIBBLE, serial);
                  s_nxt.st = S_RUN_HI;
               end
            end
         end
         S_WAIT_SEED: begin
            if (seed_valid) begin
               s_nxt.seed_hi = upper_from_seed(seed_word, seed_kind, s_r.ser);
               s_nxt.seed_lo = seed_word[31:0];
               s_nxt.st = S_RUN_HI;
            end
         end
         S_RUN_HI: begin
            if (method_xor) begin
               s_nxt.key[63:32] = xor_half(s_r.seed_hi, s_r.mfr[63:32]);
               s_nxt.key[31:0] = xor_half(s_r.seed_lo, s_r.mfr[31:0]);
               s_nxt.st = S_DONE;
            end else begin
               s_nxt.dec_start = 1'b1;
               s_nxt.st = S_WAIT_HI;
            end
         end
         S_WAIT_HI: begin
            if (dec_done) begin
               s_nxt.key[63:32] = dec_out;
               s_nxt.st = S_RUN_LO;
            end
         end
         S_RUN_LO: begin
            s_nxt.dec_start = 1'b1;
            s_nxt.st = S_WAIT_LO;
         end
         S_WAIT_LO: begin
            if (dec_done) begin
               s_nxt.key[31:0] = dec_out;
               s_nxt.st = S_DONE;
            end
         end
         S_DONE: begin
            s_nxt.key_vld = 1'b1;
            s_nxt.ok = 1'b1;
            s_nxt.st = S_IDLE;
         end
         default: begin
            s_nxt.st = S_IDLE;
         end
      endcase

      // stop from software abandons a learn still waiting for its seed
      if (stop_cmd && s_r.st == S_WAIT_SEED) begin
         s_nxt.st = S_IDLE;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
         s_r.st <= S_IDLE;
         s_r.cfg <= CFG_RESET;
         s_r.mfr <= MFR_RESET;
         s_r.pin_prev <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign learn_indication = s_r.ind;
   assign crypt_key = s_r.key;
   assign key_valid = s_r.key_vld;
   assign erase_all = s_r.erase;
endmodule
`default_nettype wire

// ---- learn_key_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module learn_key_checker
   import learn_key_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [WORD_W-1:0] rx_word,
   input wire logic [LEN_W-1:0] rx_len,
   input wire logic rx_valid,
   input wire logic [63:0] crypt_key,
   input wire logic key_valid,
   input wire logic erase_all,
   input wire logic [3:0] buttons,
   input wire logic [9:0] disc_bits,
   input wire logic [15:0] sync_value,
   input wire logic [3:0] func_bits,
   input wire logic [31:0] serial,
   input wire logic serial28,
   input wire logic parsed_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   AST_PARSE_NEXT: assert property (rx_valid |=> parsed_valid)
      else $error("parse result missing");
   AST_ENC_FIELDS: assert property (parsed_valid |-> buttons == $past(rx_word[31:28])
      && disc_bits == $past(rx_word[25:16]) && sync_value == $past(rx_word[15:0]))
      else $error("encrypted fields wrong");
   AST_SER_CLASS: assert property (parsed_valid |-> serial28 ==
      ($past(rx_len) == LEN_SHORT_A || $past(rx_len) == LEN_SHORT_B))
      else $error("encoder class wrong");
   AST_SER28_FIELDS: assert property (parsed_valid && serial28 |->
      serial == {4'h0, $past(rx_word[59:32])} && func_bits == $past(rx_word[63:60]))
      else $error("plain fields wrong");
   AST_KEY_PULSE: assert property (key_valid |=> !key_valid)
      else $error("key valid too long");
   AST_KEY_HOLD: assert property (key_valid |=> $stable(crypt_key) [*3])
      else $error("key not held");
   AST_ERASE_NEXT: assert property (reg_wr && reg_addr == OFS_MFR_HI |=> erase_all)
      else $error("erase missing");
   AST_ERASE_CAUSE: assert property (erase_all |-> $past(reg_wr && reg_addr == OFS_MFR_HI))
      else $error("erase without code write");
   AST_KEY_HI_RD: assert property (reg_rd && reg_addr == OFS_KEY_HI |=>
      reg_rdata == $past(crypt_key[63:32]))
      else $error("key read wrong");
   COV_KEY: cover property (key_valid);
   COV_ERASE: cover property (erase_all);
   COV_SER28: cover property (parsed_valid && serial28);
endmodule
`default_nettype wire

// ---- remote_encoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module remote_encoder
   import learn_key_pkg::*;
(
   input wire logic ref_clk,
   output logic [WORD_W-1:0] rx_word,
   output logic [LEN_W-1:0] rx_len,
   output logic rx_valid,
   output logic [SEED_W-1:0] seed_word,
   output logic [1:0] seed_kind,
   output logic seed_valid
);
   initial begin
      rx_word = '0;
      rx_len = '0;
      rx_valid = 1'b0;
      seed_word = '0;
      seed_kind = '0;
      seed_valid = 1'b0;
   end
   // encrypted 32 bits first, then serial, function and status
   task automatic send_code(input logic [27:0] ser, input logic [31:0] enc, input logic [LEN_W-1:0] len);
      @(posedge ref_clk);
      rx_word <= {3'h0, 2'h1, 4'hA, ser, enc};
      rx_len <= len;
      rx_valid <= 1'b1;
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      rx_word <= ~rx_word; // released lines must not keep the old word
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic send_seed(input logic [63:0] seed, input logic [1:0] kind);
      @(posedge ref_clk);
      seed_word <= seed;
      seed_kind <= kind;
      seed_valid <= 1'b1;
      @(posedge ref_clk);
      seed_valid <= 1'b0;
      seed_word <= ~seed_word;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   import learn_key_pkg::*;
   localparam logic [63:0] M = 64'hF0E1D2C3B4A59687;
   localparam logic [27:0] S = 28'h1234567;
   localparam logic [63:0] Q = 64'hFEDCBA9876543210;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic learn_request_pin_n = 1'b1;
   logic [31:0] d;
   int err_total = 0;
   int n_tests = 0;
   wire logic [WORD_W-1:0] rx_word;
   wire logic [LEN_W-1:0] rx_len;
   wire logic rx_valid, seed_valid, learn_indication, key_valid, erase_all, serial28, parsed_valid;
   wire logic [SEED_W-1:0] seed_word;
   wire logic [1:0] seed_kind, ovf_bits, status_bits;
   wire logic [31:0] reg_rdata, serial;
   wire logic [63:0] crypt_key;
   wire logic [3:0] buttons, func_bits;
   wire logic [9:0] disc_bits;
   wire logic [15:0] sync_value;
   always #10 ref_clk = ~ref_clk;
   remote_encoder remote_encoder_inst (.ref_clk(ref_clk), .rx_word(rx_word), .rx_len(rx_len),
      .rx_valid(rx_valid), .seed_word(seed_word), .seed_kind(seed_kind), .seed_valid(seed_valid));
   learn_key_generator learn_key_generator_inst (.ref_clk(ref_clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_word(rx_word), .rx_len(rx_len), .rx_valid(rx_valid),
      .seed_word(seed_word), .seed_kind(seed_kind), .seed_valid(seed_valid),
      .learn_request_pin_n(learn_request_pin_n), .learn_indication(learn_indication),
      .crypt_key(crypt_key), .key_valid(key_valid), .erase_all(erase_all), .buttons(buttons),
      .ovf_bits(ovf_bits), .disc_bits(disc_bits), .sync_value(sync_value),
      .status_bits(status_bits), .func_bits(func_bits), .serial(serial), .serial28(serial28),
      .parsed_valid(parsed_valid));
   task automatic results();
      if (err_total == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // polls every cycle because the key pulse stands only one cycle
   task automatic wait_key(output int n);
      n = 0;
      while (key_valid !== 1'b1 && n < 1500) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(key_valid, 1'b1);
   endtask
   task automatic learn(input logic [7:0] cfg, input logic [63:0] seed, input logic [1:0] kind,
      output int n);
      wr(OFS_CFG, {24'h0, cfg});
      wr(OFS_CTRL, 32'h1);
      fork
         begin
            remote_encoder_inst.send_code(S, 32'h5A3C1234, LEN_SHORT_A);
            if (cfg[CFG_SEED_BIT]) remote_encoder_inst.send_seed(seed, kind);
         end
         wait_key(n);
      join
      chk(serial, {4'h0, S});
      chk({buttons, ovf_bits, sync_value}, 22'h161234);
      chk({status_bits, func_bits}, 6'h1A);
   endtask
   task automatic long_word();
      remote_encoder_inst.send_code(S, 32'h5A3C1234, 7'h45);
      chk(serial, {4'hA, S});
      chk({serial28, status_bits, func_bits}, 7'h01);
   endtask
   task automatic abort_learn();
      @(posedge ref_clk);
      learn_request_pin_n <= 1'b0;
      @(posedge ref_clk);
      learn_request_pin_n <= 1'b1;
      remote_encoder_inst.send_code(28'h0, 32'h5A3C1234, LEN_SHORT_A);
      rd(OFS_STATUS, d);
      chk(d, 32'h15);
      wr(OFS_CFG, 32'h5);
      wr(OFS_CTRL, 32'h1);
      remote_encoder_inst.send_code(S, 32'h5A3C1234, LEN_SHORT_A);
      rd(OFS_STATUS, d);
      chk(d, 32'h19);
      wr(OFS_CTRL, 32'h2);
      rd(OFS_STATUS, d);
      chk(d, 32'h10);
   endtask
   task automatic xor_learn(input logic [7:0] cfg, input logic [63:0] seed, input logic [1:0] kind,
      input logic [31:0] hi, input logic [31:0] lo);
      int n;
      learn(cfg, seed, kind, n);
      chk(crypt_key, {hi ^ M[63:32], lo ^ M[31:0]});
      rd(OFS_STATUS, d);
      chk(d, 32'h13);
      rd(OFS_KEY_HI, d);
      chk(d, hi ^ M[63:32]);
      @(posedge ref_clk);
      learn_request_pin_n <= 1'b0;
      @(posedge ref_clk);
      learn_request_pin_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(learn_indication, 1'b0);
   endtask
   task automatic decrypt_learn();
      int n;
      learn(8'h00, Q, SEED_KIND_32, n);
      chk(n >= 2 * CIPHER_ROUNDS, 1'b1);
      chk(crypt_key == {{4'h6, S} ^ M[63:32], {4'h2, S} ^ M[31:0]}, 1'b0);
      chk(crypt_key[63:32] == crypt_key[31:0], 1'b0);
   endtask
   initial begin
      #(20 * 20000);
      err_total++;
      results();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      wr(OFS_MFR_LO, M[31:0]);
      wr(OFS_MFR_HI, M[63:32]);
      #1;
      chk(erase_all, 1'b1);
      rd(8'hFC, d);
      chk(d, 32'h0);
      long_word();
      abort_learn();
      xor_learn(8'h01, Q, SEED_KIND_32, {4'h6, S}, {4'h2, S});
      xor_learn(8'h05, Q, SEED_KIND_32, {4'h0, S}, Q[31:0]);
      xor_learn(8'h05, Q, SEED_KIND_48, {4'h0, S[27:16], Q[47:32]}, Q[31:0]);
      xor_learn(8'h05, Q, SEED_KIND_60, {4'h0, Q[59:32]}, Q[31:0]);
      decrypt_learn();
      results();
   end
endmodule
bind learn_key_generator learn_key_checker learn_key_checker_inst (.ref_clk(ref_clk), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_word(rx_word),
   .rx_len(rx_len), .rx_valid(rx_valid), .crypt_key(crypt_key), .key_valid(key_valid),
   .erase_all(erase_all), .buttons(buttons), .disc_bits(disc_bits), .sync_value(sync_value),
   .func_bits(func_bits), .serial(serial), .serial28(serial28), .parsed_valid(parsed_valid));
`default_nettype wire
